// File: src/ghc_port.sv
// gauge host port: two-wire slave, one-way switch to the single-wire link, user command port
// Functional notes
// - two-wire transfers accepted at up to 100 kHz and 400 kHz clock
// - a configuration input moves host traffic onto the single-wire data pin
// - once single-wire is chosen the two-wire interface never returns
// - device bits: low 32 to 50 us for one, 80 to 145 us for zero
// - device bit cycle lasts 190 to 250 us, nominal 205 us
// - device reply starts 190 to 950 us after the read command ends
// - line held low 2.2 s is taken as a reset request
`timescale 1ns/1ps
`default_nettype none
`include "ghc_map.svh"
module ghc_port #(
  parameter logic [6:0] SLAVE_ADDR = `GHC_SLAVE_ADDR,
  parameter int LINK_CLK_NS = `GHC_LINK_CLK_NS,
  parameter int RST_CYC = int'(longint'(`GHC_T_RESET_MS) * `GHC_NS_PER_MS / LINK_CLK_NS)
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_clk,
  input wire logic i_cfg_single_wire,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [7:0] i_rd_data,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_wire_oe,
  output logic o_single_wire,
  output logic o_cmd_valid,
  output var ghc_pkg::ghc_cmd_t o_cmd,
  output logic o_wire_reset
);
  logic scl_s, sda_s, rxt_s, rstt_s;
  logic scl_q, sda_q, rxt_q, rstt_q;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic wire_rx_tgl, wire_rst_tgl;
  ghc_pkg::ghc_cmd_t wire_rx;

  // event group state
  logic rd_wait, rep_tgl;
  logic [7:0] rep_data;
  logic next_mode, next_valid, next_rd_wait, next_rep_tgl, next_wrst;
  logic [7:0] next_rep;
  ghc_pkg::ghc_cmd_t next_cmd;

  // two-wire slave state
  ghc_pkg::ghc_ist_t ist, next_ist;
  logic [7:0] i_sh, next_sh;
  logic [3:0] i_bcnt, next_bcnt;
  logic [1:0] i_bidx, next_bidx;
  logic [6:0] i_ptr, next_ptr;
  logic i_rd, next_rd, i_nack, next_nack, next_oe;
  logic i2c_ev, next_ev;
  ghc_pkg::ghc_cmd_t ev_cmd, next_ev_cmd;

  // pins and toggles from the link domain all come from outside this clock
  ghc_sync #(.W(4)) u_sync (
    .i_clk(i_sys_clk),
    .i_d({i_scl, i_sda, wire_rx_tgl, wire_rst_tgl}),
    .o_q({scl_s, sda_s, rxt_s, rstt_s})
  );

  ghc_wire_engine #(
    .LINK_CLK_NS(LINK_CLK_NS),
    .RST_CYC(RST_CYC)
  ) u_wire (
    .i_link_clk(i_link_clk),
    .i_sys_rst(i_sys_rst),
    .i_en(o_single_wire),
    .i_line(i_sda),
    .i_rep_tgl(rep_tgl),
    .i_rep_data(rep_data),
    .o_rx(wire_rx),
    .o_rx_tgl(wire_rx_tgl),
    .o_rst_tgl(wire_rst_tgl),
    .o_oe(o_wire_oe)
  );

  // bus conditions seen on the synchronised pins
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_c = scl_s && scl_q && sda_q && !sda_s;
  assign stop_c = scl_s && scl_q && !sda_q && sda_s;

  // mode latch, command hand-out, reply hand-back, link reset request
  always_comb begin
    next_mode = o_single_wire | i_cfg_single_wire;
    next_valid = 1'b0;
    next_cmd = o_cmd;
    next_rd_wait = 1'b0;
    next_rep = rep_data;
    next_rep_tgl = rep_tgl;
    next_wrst = 1'b0;
    // reply byte is looked up by the user during the read strobe
    if (rd_wait) begin
      next_rep = i_rd_data;
      if (o_single_wire) begin
        next_rep_tgl = ~rep_tgl;
      end
    end
    // word from the link is stable for far longer than the toggle takes to cross
    if (o_single_wire && (rxt_s ^ rxt_q)) begin
      next_valid = 1'b1;
      next_cmd = wire_rx;
      next_rd_wait = !wire_rx.wr;
    end else if (!o_single_wire && i2c_ev) begin
      next_valid = 1'b1;
      next_cmd = ev_cmd;
      next_rd_wait = !ev_cmd.wr;
    end
    if (o_single_wire && (rstt_s ^ rstt_q)) begin
      next_wrst = 1'b1;
    end
  end

  // event group registers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_single_wire <= 1'b0;
      o_cmd_valid <= 1'b0;
      o_cmd <= '0;
      rd_wait <= 1'b0;
      rep_data <= 8'h00;
      rep_tgl <= 1'b0;
      o_wire_reset <= 1'b0;
      o_sda_o <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rxt_q <= 1'b0;
      rstt_q <= 1'b0;
    end else begin
      o_single_wire <= next_mode;
      o_cmd_valid <= next_valid;
      o_cmd <= next_cmd;
      rd_wait <= next_rd_wait;
      rep_data <= next_rep;
      rep_tgl <= next_rep_tgl;
      o_wire_reset <= next_wrst;
      o_sda_o <= 1'b0; // open drain: only ever pulls low
      scl_q <= scl_s;
      sda_q <= sda_s;
      rxt_q <= rxt_s;
      rstt_q <= rstt_s;
    end
  end

  // two-wire slave: address, pointer byte, then data in or out
  always_comb begin
    next_ist = ist;
    next_sh = i_sh;
    next_bcnt = i_bcnt;
    next_bidx = i_bidx;
    next_ptr = i_ptr;
    next_rd = i_rd;
    next_nack = i_nack;
    next_oe = o_sda_oe;
    next_ev = 1'b0;
    next_ev_cmd = ev_cmd;
    unique case (ist)
      ghc_pkg::GHC_I_IDLE: begin
        next_oe = 1'b0;
      end
      ghc_pkg::GHC_I_RECV: begin
        if (scl_rise) begin
          next_sh = {i_sh[6:0], sda_s};
          next_bcnt = i_bcnt + 1'b1;
        end
        if (scl_fall && i_bcnt == 4'(`GHC_CMD_BITS)) begin
          next_bcnt = '0;
          next_ist = ghc_pkg::GHC_I_ACK;
          next_oe = 1'b1;
          if (i_bidx == 2'b00) begin
            if (i_sh[7:1] == SLAVE_ADDR) begin
              next_rd = i_sh[0];
              if (i_sh[0]) begin
                next_ev = 1'b1;
                next_ev_cmd = '{wr: 1'b0, addr: i_ptr, data: 8'h00};
              end
            end else begin
              // not our address: stay off the bus until the next start
              next_ist = ghc_pkg::GHC_I_IDLE;
              next_oe = 1'b0;
            end
          end else if (i_bidx == 2'b01) begin
            next_ptr = i_sh[6:0];
          end else begin
            next_ev = 1'b1;
            next_ev_cmd = '{wr: 1'b1, addr: i_ptr, data: i_sh};
          end
        end
      end
      ghc_pkg::GHC_I_ACK: begin
        if (scl_fall) begin
          next_bidx = (i_bidx == 2'(`GHC_XFER_BYTES)) ? i_bidx : i_bidx + 1'b1;
          if (i_rd) begin
            next_ist = ghc_pkg::GHC_I_SEND;
            next_sh = rep_data;
            next_oe = ~rep_data[7];
          end else begin
            next_ist = ghc_pkg::GHC_I_RECV;
            next_oe = 1'b0;
          end
        end
      end
      ghc_pkg::GHC_I_SEND: begin
        if (scl_fall) begin
          if (i_bcnt == 4'(`GHC_CMD_BITS - 1)) begin
            next_ist = ghc_pkg::GHC_I_RACK;
            next_oe = 1'b0;
            next_bcnt = '0;
          end else begin
            next_sh = {i_sh[6:0], 1'b0};
            next_oe = ~i_sh[6];
            next_bcnt = i_bcnt + 1'b1;
          end
        end
      end
      ghc_pkg::GHC_I_RACK: begin
        if (scl_rise) begin
          next_nack = sda_s;
        end
        if (scl_fall) begin
          // master ack repeats the same byte; nack ends the read
          if (i_nack) begin
            next_ist = ghc_pkg::GHC_I_IDLE;
          end else begin
            next_ist = ghc_pkg::GHC_I_SEND;
            next_sh = rep_data;
            next_oe = ~rep_data[7];
          end
        end
      end
    endcase
    if (start_c) begin
      next_ist = ghc_pkg::GHC_I_RECV;
      next_bcnt = '0;
      next_bidx = '0;
      next_oe = 1'b0;
    end else if (stop_c) begin
      next_ist = ghc_pkg::GHC_I_IDLE;
      next_oe = 1'b0;
    end
    // the shared pin belongs to the single-wire link for good
    if (o_single_wire) begin
      next_ist = ghc_pkg::GHC_I_IDLE;
      next_oe = 1'b0;
      next_ev = 1'b0;
    end
  end

  // two-wire slave registers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ist <= ghc_pkg::GHC_I_IDLE;
      i_sh <= 8'h00;
      i_bcnt <= '0;
      i_bidx <= '0;
      i_ptr <= '0;
      i_rd <= 1'b0;
      i_nack <= 1'b0;
      o_sda_oe <= 1'b0;
      i2c_ev <= 1'b0;
      ev_cmd <= '0;
    end else begin
      ist <= next_ist;
      i_sh <= next_sh;
      i_bcnt <= next_bcnt;
      i_bidx <= next_bidx;
      i_ptr <= next_ptr;
      i_rd <= next_rd;
      i_nack <= next_nack;
      o_sda_oe <= next_oe;
      i2c_ev <= next_ev;
      ev_cmd <= next_ev_cmd;
    end
  end

  property p_mode_sticky;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    $past(o_single_wire) |-> o_single_wire;
  endproperty
  a_mode_sticky: assert property (p_mode_sticky) else $error("single-wire mode was left");

  property p_pin_handover;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_single_wire ##1 o_single_wire |-> !o_sda_oe && ist == ghc_pkg::GHC_I_IDLE && !i2c_ev;
  endproperty
  a_pin_handover: assert property (p_pin_handover) else $error("two-wire slave active in single-wire mode");

  property p_strobe;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_cmd_valid |-> rd_wait == !o_cmd.wr ##1 !o_cmd_valid;
  endproperty
  a_strobe: assert property (p_strobe) else $error("command strobe malformed");
endmodule
`default_nettype wire

// File: src/ghc_map.svh
// named offsets, field sizes and link timing figures of the gauge host port
`ifndef GHC_MAP_SVH
`define GHC_MAP_SVH
// two-wire slave address; arbitrary value
`define GHC_SLAVE_ADDR 7'h55
`define GHC_CMD_BITS 8
`define GHC_XFER_BITS 16
`define GHC_XFER_BYTES 2
`define GHC_LINK_CLK_NS 80
`define GHC_NS_PER_US 1000
`define GHC_NS_PER_MS 1000000
// host pulse classification, microseconds
`define GHC_T_HOST_ONE_MAX_US 50
`define GHC_T_HOST_ZERO_MIN_US 86
`define GHC_T_HOST_ZERO_MAX_US 145
// device pulse generation, microseconds
`define GHC_T_DEV_ONE_US 40
`define GHC_T_DEV_ZERO_US 110
`define GHC_T_DEV_CYC_US 205
`define GHC_T_DEV_ONE_MIN_US 32
`define GHC_T_DEV_ONE_MAX_US 50
`define GHC_T_DEV_ZERO_MIN_US 80
`define GHC_T_DEV_ZERO_MAX_US 145
`define GHC_T_DEV_CYC_MIN_US 190
`define GHC_T_DEV_CYC_MAX_US 250
`define GHC_DEVICE_REPLY_DELAY_MIN_US 190
`define GHC_DEVICE_REPLY_DELAY_MAX_US 950
`define GHC_T_REPLY_US 250
// long-low reset, milliseconds
`define GHC_T_RESET_MS 2200
`endif

// File: src/ghc_pkg.sv
// shared types of the gauge host port
package ghc_pkg;
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } ghc_cmd_t;

  typedef enum logic [3:0] {
    GHC_W_RX  = 4'b0001,
    GHC_W_DLY = 4'b0010,
    GHC_W_LO  = 4'b0100,
    GHC_W_HI  = 4'b1000
  } ghc_wst_t;

  typedef enum logic [4:0] {
    GHC_I_IDLE = 5'b00001,
    GHC_I_RECV = 5'b00010,
    GHC_I_ACK  = 5'b00100,
    GHC_I_SEND = 5'b01000,
    GHC_I_RACK = 5'b10000
  } ghc_ist_t;
endpackage

// File: src/ghc_sync.sv
// two-flop level synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module ghc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge i_clk) begin
    meta <= i_d;
    o_q <= meta;
  end
endmodule
`default_nettype wire

// File: src/ghc_wire_engine.sv
// single-wire link engine on the link clock: host bit decode, reply, long-low reset
`timescale 1ns/1ps
`default_nettype none
`include "ghc_map.svh"
module ghc_wire_engine #(
  parameter int LINK_CLK_NS = `GHC_LINK_CLK_NS,
  parameter int RST_CYC = int'(longint'(`GHC_T_RESET_MS) * `GHC_NS_PER_MS / LINK_CLK_NS)
) (
  input wire logic i_link_clk,
  input wire logic i_sys_rst,
  input wire logic i_en,
  input wire logic i_line,
  input wire logic i_rep_tgl,
  input wire logic [7:0] i_rep_data,
  output var ghc_pkg::ghc_cmd_t o_rx,
  output logic o_rx_tgl,
  output logic o_rst_tgl,
  output logic o_oe
);
  function automatic int cyc_up(input int us);
    return (us * `GHC_NS_PER_US + LINK_CLK_NS - 1) / LINK_CLK_NS;
  endfunction
  function automatic int cyc_dn(input int us);
    return (us * `GHC_NS_PER_US) / LINK_CLK_NS;
  endfunction

  localparam int CW = $clog2(cyc_dn(`GHC_DEVICE_REPLY_DELAY_MAX_US) + 1);
  localparam int LW = $clog2(RST_CYC + 1);
  localparam logic [CW-1:0] ONE_C = CW'(cyc_up(`GHC_T_DEV_ONE_US));
  localparam logic [CW-1:0] ZERO_C = CW'(cyc_up(`GHC_T_DEV_ZERO_US));
  localparam logic [CW-1:0] CYC_C = CW'(cyc_up(`GHC_T_DEV_CYC_US));
  localparam logic [CW-1:0] REPLY_C = CW'(cyc_up(`GHC_T_REPLY_US));
  localparam logic [CW-1:0] RSPS_MIN_C = CW'(cyc_up(`GHC_DEVICE_REPLY_DELAY_MIN_US));
  localparam logic [CW-1:0] RSPS_MAX_C = CW'(cyc_dn(`GHC_DEVICE_REPLY_DELAY_MAX_US));
  localparam logic [CW-1:0] DW1_MIN_C = CW'(cyc_up(`GHC_T_DEV_ONE_MIN_US));
  localparam logic [CW-1:0] DW1_MAX_C = CW'(cyc_dn(`GHC_T_DEV_ONE_MAX_US));
  localparam logic [CW-1:0] DW0_MIN_C = CW'(cyc_up(`GHC_T_DEV_ZERO_MIN_US));
  localparam logic [CW-1:0] DW0_MAX_C = CW'(cyc_dn(`GHC_T_DEV_ZERO_MAX_US));
  localparam logic [CW-1:0] CYCD_MIN_C = CW'(cyc_up(`GHC_T_DEV_CYC_MIN_US));
  localparam logic [CW-1:0] CYCD_MAX_C = CW'(cyc_dn(`GHC_T_DEV_CYC_MAX_US));
  // midpoint between longest one and shortest zero gives margin both ways
  localparam logic [LW-1:0] THR_C = LW'(cyc_dn((`GHC_T_HOST_ONE_MAX_US + `GHC_T_HOST_ZERO_MIN_US) / 2));
  localparam logic [LW-1:0] BRK_C = LW'(cyc_dn(`GHC_T_HOST_ZERO_MAX_US));
  localparam logic [LW-1:0] RST_C = LW'(RST_CYC);

  logic rst_l, en_l, line_s, rep_s, line_q, rep_q, rep_pend, rx_bit;
  logic next_pend, next_oe, next_rx_tgl, next_rst_tgl;
  ghc_pkg::ghc_wst_t st, next_st;
  logic [CW-1:0] cnt, next_cnt;
  logic [LW-1:0] lo_cnt, next_lo;
  logic [15:0] sh, next_sh;
  logic [4:0] bitcnt, next_bits;
  logic [7:0] txb, next_txb;
  logic [2:0] bidx, next_bidx;
  ghc_pkg::ghc_cmd_t next_rx;

  ghc_sync #(.W(4)) u_sync (
    .i_clk(i_link_clk),
    .i_d({i_sys_rst, i_en, i_line, i_rep_tgl}),
    .o_q({rst_l, en_l, line_s, rep_s})
  );

  // next state of the link engine
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_lo = lo_cnt;
    next_sh = sh;
    next_bits = bitcnt;
    next_txb = txb;
    next_bidx = bidx;
    next_pend = rep_pend | (rep_s ^ rep_q);
    next_rx = o_rx;
    next_rx_tgl = o_rx_tgl;
    next_rst_tgl = o_rst_tgl;
    next_oe = o_oe;
    rx_bit = 1'b0;
    unique case (st)
      ghc_pkg::GHC_W_RX: begin
        next_lo = line_s ? '0 : ((lo_cnt == RST_C) ? lo_cnt : lo_cnt + 1'b1);
        if (!line_s && lo_cnt == RST_C - 1'b1) begin
          next_rst_tgl = ~o_rst_tgl;
        end
        if (line_s && !line_q) begin
          if (lo_cnt > BRK_C) begin
            next_bits = '0;
          end else begin
            rx_bit = (lo_cnt <= THR_C);
            next_sh = {rx_bit, sh[15:1]};
            next_bits = bitcnt + 1'b1;
            if (bitcnt == 5'(`GHC_CMD_BITS - 1) && !rx_bit) begin
              // read command: flag bit clear, reply follows
              next_rx = '{wr: 1'b0, addr: sh[15:9], data: 8'h00};
              next_rx_tgl = ~o_rx_tgl;
              next_bits = '0;
              next_cnt = '0;
              next_pend = 1'b0; // a reply that came too late for an older read must not answer this one
              next_st = ghc_pkg::GHC_W_DLY;
            end else if (bitcnt == 5'(`GHC_XFER_BITS - 1)) begin
              next_rx = '{wr: 1'b1, addr: sh[7:1], data: {rx_bit, sh[15:9]}};
              next_rx_tgl = ~o_rx_tgl;
              next_bits = '0;
            end
          end
        end
      end
      ghc_pkg::GHC_W_DLY: begin
        next_cnt = cnt + 1'b1;
        if (rep_pend && cnt >= REPLY_C) begin
          next_st = ghc_pkg::GHC_W_LO;
          next_oe = 1'b1;
          next_cnt = '0;
          next_bidx = '0;
          next_txb = i_rep_data;
          next_pend = 1'b0;
        end else if (cnt == RSPS_MAX_C - 1'b1) begin
          // reply never arrived in time: stay silent rather than answer late
          next_st = ghc_pkg::GHC_W_RX;
        end
      end
      ghc_pkg::GHC_W_LO: begin
        next_cnt = cnt + 1'b1;
        if (cnt == (txb[0] ? ONE_C : ZERO_C) - 1'b1) begin
          next_oe = 1'b0;
          next_st = ghc_pkg::GHC_W_HI;
        end
      end
      ghc_pkg::GHC_W_HI: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CYC_C - 1'b1) begin
          next_cnt = '0;
          if (bidx == 3'(`GHC_CMD_BITS - 1)) begin
            next_st = ghc_pkg::GHC_W_RX;
            next_lo = '0;
          end else begin
            next_bidx = bidx + 1'b1;
            next_txb = {1'b0, txb[7:1]};
            next_oe = 1'b1;
            next_st = ghc_pkg::GHC_W_LO;
          end
        end
      end
    endcase
    if (!en_l) begin
      next_st = ghc_pkg::GHC_W_RX;
      next_oe = 1'b0;
      next_lo = '0;
      next_bits = '0;
    end
  end

  // link engine registers
  always_ff @(posedge i_link_clk) begin
    if (rst_l) begin
      st <= ghc_pkg::GHC_W_RX;
      cnt <= '0;
      lo_cnt <= '0;
      sh <= '0;
      bitcnt <= '0;
      txb <= '0;
      bidx <= '0;
      rep_pend <= 1'b0;
      line_q <= 1'b1;
      rep_q <= 1'b0;
      o_rx <= '0;
      o_rx_tgl <= 1'b0;
      o_rst_tgl <= 1'b0;
      o_oe <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      lo_cnt <= next_lo;
      sh <= next_sh;
      bitcnt <= next_bits;
      txb <= next_txb;
      bidx <= next_bidx;
      rep_pend <= next_pend;
      line_q <= line_s;
      rep_q <= rep_s;
      o_rx <= next_rx;
      o_rx_tgl <= next_rx_tgl;
      o_rst_tgl <= next_rst_tgl;
      o_oe <= next_oe;
    end
  end

  property p_dev_pulse;
    @(posedge i_link_clk) disable iff (rst_l)
    $fell(o_oe) && st == ghc_pkg::GHC_W_HI |->
      (txb[0] ? (cnt >= DW1_MIN_C && cnt <= DW1_MAX_C) : (cnt >= DW0_MIN_C && cnt <= DW0_MAX_C));
  endproperty
  a_dev_pulse: assert property (p_dev_pulse) else $error("device pulse width out of range");

  property p_dev_cycle;
    @(posedge i_link_clk) disable iff (rst_l)
    $rose(o_oe) && bidx != 3'b000 |-> $past(cnt) >= CYCD_MIN_C - 1'b1 && $past(cnt) <= CYCD_MAX_C - 1'b1;
  endproperty
  a_dev_cycle: assert property (p_dev_cycle) else $error("device bit cycle out of range");

  property p_reply_delay;
    @(posedge i_link_clk) disable iff (rst_l)
    $rose(o_oe) && bidx == 3'b000 |-> $past(st) == ghc_pkg::GHC_W_DLY &&
      $past(cnt) >= RSPS_MIN_C && $past(cnt) <= RSPS_MAX_C;
  endproperty
  a_reply_delay: assert property (p_reply_delay) else $error("reply started outside its window");

  property p_long_low;
    @(posedge i_link_clk) disable iff (rst_l)
    $changed(o_rst_tgl) |-> $past(lo_cnt) == RST_C - 1'b1 && !$past(line_s, 1);
  endproperty
  a_long_low: assert property (p_long_low) else $error("reset flagged without a full long low");

  property p_frame;
    @(posedge i_link_clk) disable iff (rst_l)
    $changed(o_rx_tgl) |-> bitcnt == 5'd0 &&
      (o_rx.wr ? $past(bitcnt) == 5'd15 : ($past(bitcnt) == 5'd7 && st == ghc_pkg::GHC_W_DLY));
  endproperty
  a_frame: assert property (p_frame) else $error("command framed on a wrong bit count");
endmodule
`default_nettype wire

// File: sim/ghc_host_model.sv
// behavioural host controller on the single-wire line
`timescale 1ns/1ps
`default_nettype none
module ghc_host_model (
  input wire logic i_line,
  output logic o_pull_low
);
  realtime t_rise;

  // line released until a transfer starts
  initial begin
    o_pull_low = 1'b0;
    t_rise = 0;
  end

  // break then recovery gap before the first bit
  task automatic brk();
    o_pull_low = 1'b1;
    #200_000 o_pull_low = 1'b0;
    #50_000;
  endtask

  // short low is one, long low is zero, lsb first; falls 195 us apart
  task automatic send_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      o_pull_low = 1'b1;
      #(d[i] ? 10_000 : 110_000) o_pull_low = 1'b0;
      t_rise = $realtime;
      #(d[i] ? 185_000 : 85_000);
    end
  endtask

  // long low stretch asks the device for a reset
  task automatic hold_low(input int us);
    o_pull_low = 1'b1;
    #(us * 1000) o_pull_low = 1'b0;
  endtask

  // poll in 100 ns steps so a silent device cannot hang the run
  task automatic wait_lvl(input logic v, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 12000 && !ok; n++) begin
      if (i_line === v) ok = 1'b1;
      else #100;
    end
  endtask

  // times every device pulse; ok drops on any window violation
  task automatic recv_byte(output logic [7:0] d, output logic ok);
    realtime tf, tp, w;
    logic got;
    ok = 1'b1;
    d = 8'h00;
    tp = 0;
    for (int i = 0; i < 8; i++) begin
      wait_lvl(1'b0, got);
      tf = $realtime;
      if (!got) ok = 1'b0;
      if (i == 0 && (tf - t_rise < 190_000 || tf - t_rise > 950_000)) ok = 1'b0;
      if (i > 0 && (tf - tp < 190_000 || tf - tp > 250_000)) ok = 1'b0;
      wait_lvl(1'b1, got);
      w = $realtime - tf;
      if (!got) ok = 1'b0;
      d[i] = (w <= 50_000);
      if (!((w >= 32_000 && w <= 50_000) || (w >= 80_000 && w <= 145_000))) ok = 1'b0;
      tp = tf;
    end
    #250_000;
  endtask
endmodule
`default_nettype wire

// File: sim/ghc_port_tb_top.sv
// self-checking bench of the gauge host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module ghc_port_tb_top;
  logic i_sys_clk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_cfg_single_wire = 1'b0;
  logic i_scl = 1'b1;
  logic m_low = 1'b0;
  logic [7:0] i_rd_data = 8'h96;
  logic o_sda_o, o_sda_oe, o_wire_oe, o_single_wire, o_cmd_valid, o_wire_reset, host_low;
  // bits seen on the data pin during the last two-wire transfer, and quarter bit in system cycles
  logic [23:0] rd_bits;
  int qtr = 25;
  ghc_pkg::ghc_cmd_t o_cmd, cmd_seen;
  int errors = 0, check_count = 0, cmd_cnt = 0, rst_cnt = 0;
  // open-drain pin with pull-up: low when any party pulls
  wire logic line = !(o_sda_oe | o_wire_oe | m_low | host_low);

  always #12.5 i_sys_clk = ~i_sys_clk;
  // link clock offset so its edges never line up with the system clock
  initial begin
    #13;
    forever #40 i_link_clk = ~i_link_clk;
  end

  // reset count shortened so the long-low case fits the run, yet well above a break
  ghc_port #(.RST_CYC(5000)) i_ghc_port (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_link_clk(i_link_clk), .i_cfg_single_wire(i_cfg_single_wire), .i_scl(i_scl), .i_sda(line),
    .i_rd_data(i_rd_data), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_wire_oe(o_wire_oe),
    .o_single_wire(o_single_wire), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_wire_reset(o_wire_reset));
  ghc_host_model i_ghc_host_model (.i_line(line), .o_pull_low(host_low));

  // one-cycle pulses are counted in the cycle they stand
  always @(posedge i_sys_clk) begin
    if (o_cmd_valid === 1'b1) begin
      cmd_cnt++;
      cmd_seen = o_cmd;
    end
    if (o_wire_reset === 1'b1) rst_cnt++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one two-wire bit in four quarters: qtr 25 is 400 kHz, qtr 100 is 100 kHz
  task automatic i2c_bit(input logic b, output logic r);
    m_low <= !b;
    cyc(qtr);
    i_scl <= 1'b1;
    cyc(qtr);
    r = line;
    cyc(qtr);
    i_scl <= 1'b0;
    cyc(qtr);
  endtask

  // start, nb bytes msb first with acks collected, stop
  task automatic i2c_xfer(input logic [23:0] v, input int nb, output logic [2:0] ack);
    logic r;
    ack = 3'b000;
    m_low <= 1'b1;
    cyc(25);
    i_scl <= 1'b0;
    cyc(25);
    for (int k = 0; k < 8 * nb; k++) begin
      i2c_bit(v[23 - k], r);
      rd_bits[23 - k] = r;
      if (k % 8 == 7) begin
        i2c_bit(1'b1, r);
        ack[2 - k / 8] = !r;
      end
    end
    m_low <= 1'b1;
    cyc(25);
    i_scl <= 1'b1;
    cyc(25);
    m_low <= 1'b0;
    cyc(25);
  endtask

  task automatic t_i2c_write();
    logic [2:0] ack;
    int n;
    n = cmd_cnt;
    i2c_xfer({7'h55, 1'b0, 8'h12, 8'ha5}, 3, ack);
    cyc(10);
    `CHK(ack, 3'b111)
    `CHK(cmd_cnt, n + 1)
    `CHK(cmd_seen, 16'h92a5)
  endtask

  // pointer kept from the write; one byte read at standard speed, master nacks it
  task automatic t_i2c_read();
    logic [2:0] ack;
    int n;
    n = cmd_cnt;
    qtr = 100;
    i2c_xfer({7'h55, 1'b1, 16'hffff}, 2, ack);
    qtr = 25;
    cyc(10);
    `CHK(ack, 3'b100)
    `CHK(cmd_cnt, n + 1)
    `CHK(cmd_seen, 16'h1200)
    `CHK(rd_bits[15:8], 8'h96)
    `CHK(o_sda_o, 1'b0)
  endtask

  // mode latches once and a later low on the select has no effect
  task automatic t_mode_switch();
    logic [2:0] ack;
    i_cfg_single_wire <= 1'b1;
    cyc(3);
    `CHK(o_single_wire, 1'b1)
    i_cfg_single_wire <= 1'b0;
    cyc(3);
    `CHK(o_single_wire, 1'b1)
    i2c_xfer({7'h55, 1'b0, 16'h0000}, 1, ack);
    `CHK(ack[2], 1'b0)
  endtask

  // the probe above left partial bits: break clears them
  task automatic t_sw_write();
    int n, k;
    n = cmd_cnt;
    k = rst_cnt;
    i_ghc_host_model.brk();
    i_ghc_host_model.send_byte(8'h85);
    i_ghc_host_model.send_byte(8'h3c);
    cyc(20);
    `CHK(rst_cnt, k)
    `CHK(cmd_cnt, n + 1)
    `CHK(cmd_seen, 16'h853c)
  endtask

  task automatic t_sw_read();
    logic [7:0] d;
    logic ok;
    i_rd_data <= 8'h69;
    i_ghc_host_model.send_byte(8'h21);
    i_ghc_host_model.recv_byte(d, ok);
    `CHK({cmd_seen.wr, cmd_seen.addr}, 8'h21)
    `CHK(d, 8'h69)
    `CHK(ok, 1'b1)
    `CHK(o_wire_oe, 1'b0)
  endtask

  task automatic t_long_low();
    int n;
    n = rst_cnt;
    i_ghc_host_model.hold_low(450);
    cyc(20);
    `CHK(rst_cnt, n + 1)
  endtask

  // hard limit in case a wait never ends
  initial begin
    #20_000_000;
    errors++;
    end_sim();
  end

  // six system cycles always cover a link edge, so the synchronised reset reaches the link side
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    cyc(5);
    t_i2c_write();
    t_i2c_read();
    t_mode_switch();
    t_sw_write();
    t_sw_read();
    t_long_low();
    end_sim();
  end
endmodule
`default_nettype wire
